// [src/usb_frame_aux_control.sv]
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
// How it works
// - sixteen-bit endpoint mask, zero at reset, read/write
// - masked received endpoint leaves with 0x10 set
// - full 32-bit on-the-go mask, zero at reset
// - power data byte plus valid bit 8
// - control bit 18 disables data-line pulldowns
// - SE0 auto-resume sets bit 13, write zero clears
// - K auto-resume sets bit 12, write zero clears
// - line change passes after 2^n + 1 stable clocks
// - bit 7 enables hardware suspend/resume handling
// - bits 6:4 drive the three PHY config pins
module usb_frame_aux_control
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // receive endpoint path
  input wire logic [3:0] rxEndpoint,
  input wire logic rxEndpointValid,
  output logic [4:0] rxPortEndpoint,
  output logic rxPortValid,
  // phy line state and suspend
  input wire logic [1:0] lineStatePin,
  input wire logic suspendRequest,
  output logic phySuspendN,
  output logic [1:0] lineStateFiltered,
  // phy pins
  output logic usbDataPortAPulldown,
  output logic usbDataPortBPulldown,
  output logic [2:0] phyConfigPins,
  // power signalling and on-the-go
  output logic [7:0] powerSignalData,
  output logic powerSignalValid,
  output logic [31:0] onTheGoFlagMask,
  // interrupt
  output logic irq
);
  // ==========================================================
  // declarations
  logic [31:0] epMatch_r;
  logic [31:0] epMatch_nxt;
  logic [31:0] otgMask_r;
  logic [31:0] otgMask_nxt;
  logic [31:0] pwrSig_r;
  logic [31:0] pwrSig_nxt;
  logic [31:0] phyCtrl_r;
  logic [31:0] phyCtrl_nxt;
  logic [31:0] irqStat_r;
  logic [31:0] irqStat_nxt;
  logic [31:0] irqMask_r;
  logic [31:0] irqMask_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] datOut_r;
  logic [31:0] datOut_nxt;
  logic [4:0] rxEp_r;
  logic [4:0] rxEp_nxt;
  logic rxValid_r;
  logic rxValid_nxt;
  logic [1:0] lineMeta_r;
  logic [1:0] lineSync_r;
  ufa_pkg::ufa_susp_e susp_r;
  ufa_pkg::ufa_susp_e susp_nxt;
  logic req;
  logic commit;
  logic wrCommit;
  logic rdCommit;
  logic resumeK;
  logic resumeSe0;
  logic [31:0] readMux;

  ufa_filt_if filtBus ();

  // ==========================================================
  // helpers
  // byte-lane merge limited to writable bits
  function automatic logic [31:0] wmerge
  (
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] sel,
    input logic [31:0] wmask
  );
    logic [31:0] lanes;
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wmerge = (old & ~(lanes & wmask)) | (wdata & lanes & wmask);
  endfunction : wmerge

  function automatic logic hit
  (
    input logic [7:0] adr,
    input logic [7:0] target
  );
    hit = adr[7:2] == target[7:2];
  endfunction : hit

  // ==========================================================
  // bus handshake
  // ack follows one cycle after the request; write and read-clear
  // take effect on the edge that the master samples ack
  assign req = wb_cyc_i & wb_stb_i;
  assign commit = req & ack_r;
  assign wrCommit = commit & wb_we_i;
  assign rdCommit = commit & ~wb_we_i;

  always_comb
  begin
    readMux = 32'h0000_0000;
    if (hit(wb_adr_i, ufa_pkg::EP_MATCH_ADDR))
      readMux = epMatch_r;
    else if (hit(wb_adr_i, ufa_pkg::OTG_MASK_ADDR))
      readMux = otgMask_r;
    else if (hit(wb_adr_i, ufa_pkg::PWR_SIG_ADDR))
      readMux = pwrSig_r;
    else if (hit(wb_adr_i, ufa_pkg::PHY_CTRL_ADDR))
      readMux = phyCtrl_r;
    else if (hit(wb_adr_i, ufa_pkg::IRQ_STAT_ADDR))
      readMux = irqStat_r;
    else if (hit(wb_adr_i, ufa_pkg::IRQ_MASK_ADDR))
      readMux = irqMask_r;
    else if (hit(wb_adr_i, ufa_pkg::LINE_STAT_ADDR))
      readMux = {30'h0000_0000, filtBus.lineFilt};
    ack_nxt = req & ~ack_r;
    datOut_nxt = (req & ~ack_r & ~wb_we_i) ? readMux : 32'h0000_0000;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ack_r <= 1'b0;
      datOut_r <= ufa_pkg::REG_RESET;
    end
    else
    begin
      ack_r <= ack_nxt;
      datOut_r <= datOut_nxt;
    end
  end

  // ==========================================================
  // line state synchroniser and filter
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      lineMeta_r <= 2'h0;
      lineSync_r <= 2'h0;
    end
    else
    begin
      lineMeta_r <= lineStatePin;
      lineSync_r <= lineMeta_r;
    end
  end

  assign filtBus.lineSync = lineSync_r;
  assign filtBus.log2Clocks = phyCtrl_r[ufa_pkg::PHY_SHIFT_LSB +: 4];

  ufa_line_filter lineFilter
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .fl(filtBus.filt)
  );

  // ==========================================================
  // suspend controller
  // without the enable software polls the filtered line state
  always_comb
  begin
    susp_nxt = susp_r;
    resumeK = 1'b0;
    resumeSe0 = 1'b0;
    case (susp_r)
      ufa_pkg::SUSP_AWAKE:
      begin
        if (phyCtrl_r[ufa_pkg::PHY_HW_SUSP_BIT] && suspendRequest)
          susp_nxt = ufa_pkg::SUSP_ASLEEP;
      end
      ufa_pkg::SUSP_ASLEEP:
      begin
        if (!phyCtrl_r[ufa_pkg::PHY_HW_SUSP_BIT])
          susp_nxt = ufa_pkg::SUSP_AWAKE;
        else if (filtBus.lineChanged && filtBus.lineFilt == ufa_pkg::LINE_K)
        begin
          resumeK = 1'b1;
          susp_nxt = ufa_pkg::SUSP_AWAKE;
        end
        else if (filtBus.lineChanged &&
                 filtBus.lineFilt == ufa_pkg::LINE_SE0)
        begin
          resumeSe0 = 1'b1;
          susp_nxt = ufa_pkg::SUSP_AWAKE;
        end
      end
      default:
        susp_nxt = ufa_pkg::SUSP_AWAKE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      susp_r <= ufa_pkg::SUSP_AWAKE;
    else
      susp_r <= susp_nxt;
  end

  // ==========================================================
  // registers
  // hardware set wins over a software clear in the same cycle
  always_comb
  begin
    epMatch_nxt = epMatch_r;
    otgMask_nxt = otgMask_r;
    pwrSig_nxt = pwrSig_r;
    phyCtrl_nxt = phyCtrl_r;
    irqMask_nxt = irqMask_r;
    irqStat_nxt = irqStat_r;
    if (wrCommit && hit(wb_adr_i, ufa_pkg::EP_MATCH_ADDR))
      epMatch_nxt = wmerge(epMatch_r, wb_dat_i, wb_sel_i,
                           ufa_pkg::EP_MATCH_WMASK);
    if (wrCommit && hit(wb_adr_i, ufa_pkg::OTG_MASK_ADDR))
      otgMask_nxt = wmerge(otgMask_r, wb_dat_i, wb_sel_i,
                           ufa_pkg::OTG_MASK_WMASK);
    if (wrCommit && hit(wb_adr_i, ufa_pkg::PWR_SIG_ADDR))
      pwrSig_nxt = wmerge(pwrSig_r, wb_dat_i, wb_sel_i,
                          ufa_pkg::PWR_SIG_WMASK);
    if (wrCommit && hit(wb_adr_i, ufa_pkg::PHY_CTRL_ADDR))
      phyCtrl_nxt = wmerge(phyCtrl_r, wb_dat_i, wb_sel_i,
                           ufa_pkg::PHY_CTRL_WMASK);
    if (wrCommit && hit(wb_adr_i, ufa_pkg::IRQ_MASK_ADDR))
      irqMask_nxt = wmerge(irqMask_r, wb_dat_i, wb_sel_i,
                           ufa_pkg::IRQ_WMASK);
    // clear only what the read returned: an event landing between the
    // latch edge and the ack edge stays pending instead of being lost
    if (rdCommit && hit(wb_adr_i, ufa_pkg::IRQ_STAT_ADDR))
      irqStat_nxt = irqStat_r & ~datOut_r;
    if (resumeK)
    begin
      phyCtrl_nxt[ufa_pkg::PHY_K_BIT] = 1'b1;
      irqStat_nxt[ufa_pkg::IRQ_K_BIT] = 1'b1;
    end
    if (resumeSe0)
    begin
      phyCtrl_nxt[ufa_pkg::PHY_SE0_BIT] = 1'b1;
      irqStat_nxt[ufa_pkg::IRQ_SE0_BIT] = 1'b1;
    end
    if (filtBus.lineChanged)
      irqStat_nxt[ufa_pkg::IRQ_LINE_BIT] = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      epMatch_r <= ufa_pkg::REG_RESET;
      otgMask_r <= ufa_pkg::REG_RESET;
      pwrSig_r <= ufa_pkg::REG_RESET;
      phyCtrl_r <= ufa_pkg::REG_RESET;
      irqStat_r <= ufa_pkg::REG_RESET;
      irqMask_r <= ufa_pkg::REG_RESET;
    end
    else
    begin
      epMatch_r <= epMatch_nxt;
      otgMask_r <= otgMask_nxt;
      pwrSig_r <= pwrSig_nxt;
      phyCtrl_r <= phyCtrl_nxt;
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
    end
  end

  // ==========================================================
  // receive endpoint tagging
  always_comb
  begin
    rxValid_nxt = rxEndpointValid;
    rxEp_nxt = rxEp_r;
    if (rxEndpointValid)
    begin
      rxEp_nxt = {1'b0, rxEndpoint};
      if (epMatch_r[rxEndpoint])
        rxEp_nxt = rxEp_nxt | ufa_pkg::EP_SPECIAL_FLAG;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rxEp_r <= 5'h00;
      rxValid_r <= 1'b0;
    end
    else
    begin
      rxEp_r <= rxEp_nxt;
      rxValid_r <= rxValid_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign wb_dat_o = datOut_r;
  assign wb_ack_o = ack_r;
  assign rxPortEndpoint = rxEp_r;
  assign rxPortValid = rxValid_r;
  assign phySuspendN = (susp_r == ufa_pkg::SUSP_AWAKE);
  assign lineStateFiltered = filtBus.lineFilt;
  assign usbDataPortAPulldown = ~phyCtrl_r[ufa_pkg::PHY_PD_OFF_BIT];
  assign usbDataPortBPulldown = ~phyCtrl_r[ufa_pkg::PHY_PD_OFF_BIT];
  assign phyConfigPins = phyCtrl_r[ufa_pkg::PHY_CONF_LSB +: 3];
  assign powerSignalData = pwrSig_r[7:0];
  assign powerSignalValid = pwrSig_r[ufa_pkg::PWR_VALID_BIT];
  assign onTheGoFlagMask = otgMask_r;
  assign irq = |(irqStat_r & irqMask_r);
endmodule : usb_frame_aux_control

// [include/ufa_pkg.sv]
package ufa_pkg;
  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] EP_MATCH_ADDR = 8'h34;
  localparam logic [7:0] OTG_MASK_ADDR = 8'h38;
  localparam logic [7:0] PWR_SIG_ADDR = 8'h3C;
  localparam logic [7:0] PHY_CTRL_ADDR = 8'h40;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h44;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h48;
  localparam logic [7:0] LINE_STAT_ADDR = 8'h4C;
  // ==========================================================
  // writable bits of each register, reset values
  localparam logic [31:0] EP_MATCH_WMASK = 32'h0000_FFFF;
  localparam logic [31:0] OTG_MASK_WMASK = 32'hFFFF_FFFF;
  localparam logic [31:0] PWR_SIG_WMASK = 32'h0000_01FF;
  localparam logic [31:0] PHY_CTRL_WMASK = 32'h0004_3FF0;
  localparam logic [31:0] IRQ_WMASK = 32'h0000_0007;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // ==========================================================
  // field positions
  localparam int PWR_VALID_BIT = 8;
  localparam int PHY_PD_OFF_BIT = 18;
  localparam int PHY_SE0_BIT = 13;
  localparam int PHY_K_BIT = 12;
  localparam int PHY_SHIFT_LSB = 8;
  localparam int PHY_HW_SUSP_BIT = 7;
  localparam int PHY_CONF_LSB = 4;
  localparam int IRQ_K_BIT = 0;
  localparam int IRQ_SE0_BIT = 1;
  localparam int IRQ_LINE_BIT = 2;
  localparam logic [4:0] EP_SPECIAL_FLAG = 5'h10;
  // ==========================================================
  // line state codes and filter sizing
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_K = 2'h2;
  localparam int FILT_CNT_W = 16;
  typedef enum logic [0:0]
  {
    SUSP_AWAKE = 1'b0,
    SUSP_ASLEEP = 1'b1
  } ufa_susp_e;
endpackage : ufa_pkg

// [include/ufa_filt_if.sv]
`timescale 1ns/100ps
interface ufa_filt_if;
  logic [3:0] log2Clocks;
  logic [1:0] lineSync;
  logic [1:0] lineFilt;
  logic lineChanged;
  modport ctrl
  (
    output log2Clocks,
    output lineSync,
    input lineFilt,
    input lineChanged
  );
  modport filt
  (
    input log2Clocks,
    input lineSync,
    output lineFilt,
    output lineChanged
  );
endinterface : ufa_filt_if

// [src/ufa_line_filter.sv]
`timescale 1ns/100ps
module ufa_line_filter
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // control side
  ufa_filt_if.filt fl
);
  logic [1:0] cand_r;
  logic [1:0] cand_nxt;
  logic [1:0] filt_r;
  logic [1:0] filt_nxt;
  logic [ufa_pkg::FILT_CNT_W-1:0] cnt_r;
  logic [ufa_pkg::FILT_CNT_W-1:0] cnt_nxt;
  logic chg_r;
  logic chg_nxt;
  logic [ufa_pkg::FILT_CNT_W-1:0] limit;

  // ==========================================================
  // persistence filter
  // a new level must hold 2^n + 1 clocks; any bounce restarts the count
  always_comb
  begin
    limit = ufa_pkg::FILT_CNT_W'(1) << fl.log2Clocks;
    cand_nxt = fl.lineSync;
    filt_nxt = filt_r;
    cnt_nxt = '0;
    chg_nxt = 1'b0;
    if (fl.lineSync != filt_r && fl.lineSync == cand_r)
    begin
      if (cnt_r + ufa_pkg::FILT_CNT_W'(1) >= limit)
      begin
        filt_nxt = cand_r;
        chg_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + ufa_pkg::FILT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cand_r <= 2'h0;
      filt_r <= 2'h0;
      cnt_r <= '0;
      chg_r <= 1'b0;
    end
    else
    begin
      cand_r <= cand_nxt;
      filt_r <= filt_nxt;
      cnt_r <= cnt_nxt;
      chg_r <= chg_nxt;
    end
  end

  assign fl.lineFilt = filt_r;
  assign fl.lineChanged = chg_r;
endmodule : ufa_line_filter

// [testbench/ufa_aux_assertions.sv]
`timescale 1ns/100ps
// ====
// register to pin and pin to pin relations at the block boundary
module ufa_aux_assertions
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // bus
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // endpoint path
  input wire logic [3:0] rxEndpoint,
  input wire logic rxEndpointValid,
  input wire logic [4:0] rxPortEndpoint,
  input wire logic rxPortValid,
  // line and pins
  input wire logic [1:0] lineStatePin,
  input wire logic suspendRequest,
  input wire logic phySuspendN,
  input wire logic [1:0] lineStateFiltered,
  input wire logic usbDataPortAPulldown,
  input wire logic [2:0] phyConfigPins,
  input wire logic [7:0] powerSignalData,
  input wire logic powerSignalValid,
  input wire logic [31:0] onTheGoFlagMask
);
  logic wr;
  logic [5:0] wa;
  assign wr = wb_ack_o & wb_we_i;
  assign wa = wb_adr_i[7:2];
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_pd_write:
  assert property (wr && wa == 6'h10 && wb_sel_i[2] |=>
    usbDataPortAPulldown == !$past(wb_dat_i[18])) else $error("pulldown");
  a_conf_write:
  assert property (wr && wa == 6'h10 && wb_sel_i[0] |=>
    phyConfigPins == $past(wb_dat_i[6:4])) else $error("config pins");
  a_otg_write:
  assert property (wr && wa == 6'h0E && wb_sel_i == 4'hF |=>
    onTheGoFlagMask == $past(wb_dat_i)) else $error("otg mask");
  a_pwr_write:
  assert property (wr && wa == 6'h0F && wb_sel_i[1:0] == 2'h3 |=>
    {powerSignalValid, powerSignalData} == $past(wb_dat_i[8:0]))
    else $error("power");
  a_rsvd_read:
  assert property (wb_ack_o && !wb_we_i && wa == 6'h0D |->
    wb_dat_o[31:16] == 16'h0) else $error("reserved bits");
  a_rx_path:
  assert property (rxEndpointValid |=> rxPortValid &&
    rxPortEndpoint[3:0] == $past(rxEndpoint)) else $error("rx path");
  // two sync stages plus the filter register: the new level is the
  // pin value from three samples back
  a_line_filter:
  assert property ($changed(lineStateFiltered) |->
    lineStateFiltered == $past(lineStatePin, 3)) else $error("filter");
  a_sleep_req:
  assert property ($fell(phySuspendN) |-> $past(suspendRequest))
    else $error("sleep");
endmodule : ufa_aux_assertions

bind usb_frame_aux_control ufa_aux_assertions u_ufa_aux_assertions
(
  .clock, .sys_rst, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .rxEndpoint, .rxEndpointValid, .rxPortEndpoint,
  .rxPortValid, .lineStatePin, .suspendRequest, .phySuspendN,
  .lineStateFiltered, .usbDataPortAPulldown, .phyConfigPins,
  .powerSignalData, .powerSignalValid, .onTheGoFlagMask
);

// [testbench/ufa_phy_model.sv]
`timescale 1ns/100ps
// ====
// phy side: linestate launched from a register, as the phy does
module ufa_phy_model
(
  // clock
  input wire logic clock,
  // symbol chosen by the bench
  input wire logic [1:0] lineReq,
  // linestate toward the block
  output logic [1:0] lineStatePin
);
  always_ff @(posedge clock)
  begin
    lineStatePin <= lineReq;
  end
endmodule : ufa_phy_model

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] rxEndpoint = 4'h0;
  logic rxEndpointValid = 1'b0;
  logic suspendRequest = 1'b0;
  logic [1:0] lineReq = 2'h1;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [4:0] rxPortEndpoint;
  logic rxPortValid;
  logic [1:0] lineStatePin;
  logic phySuspendN;
  logic [1:0] lineStateFiltered;
  logic usbDataPortAPulldown;
  logic usbDataPortBPulldown;
  logic [2:0] phyConfigPins;
  logic [7:0] powerSignalData;
  logic powerSignalValid;
  logic [31:0] onTheGoFlagMask;
  logic irq;
  int fails = 0;
  int checkCount = 0;

  always #25 clock = ~clock;

  usb_frame_aux_control u_usb_frame_aux_control
  (
    .clock, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxEndpoint,
    .rxEndpointValid, .rxPortEndpoint, .rxPortValid, .lineStatePin,
    .suspendRequest, .phySuspendN, .lineStateFiltered,
    .usbDataPortAPulldown, .usbDataPortBPulldown, .phyConfigPins,
    .powerSignalData, .powerSignalValid, .onTheGoFlagMask, .irq
  );
  ufa_phy_model u_ufa_phy_model(.clock, .lineReq, .lineStatePin);

  task automatic complete_run();
    if (fails == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic hang();
    fails++;
    complete_run();
  endtask : hang

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checkCount++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  // ====
  // bus cycles: request held until ack is sampled
  task automatic wbx(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      hang();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wbx

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbx(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    logic [31:0] q;
    wbx(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rd

  task automatic waitf(input logic [1:0] v);
    int n;
    n = 0;
    while (lineStateFiltered !== v && n < 200)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 200)
      hang();
  endtask : waitf

  // ====
  // scenarios
  task automatic t_regs();
    logic [31:0] wm [4];
    wm = '{32'h0000FFFF, 32'hFFFFFFFF, 32'h000001FF, 32'h00043FF0};
    for (int i = 0; i < 4; i++)
    begin
      rd("reset", 8'h34 + 8'(4 * i), 32'h0);
      wr(8'h34 + 8'(4 * i), 32'hFFFFFFFF);
      rd("mask", 8'h34 + 8'(4 * i), wm[i]);
    end
    @(posedge clock);
    chk("pd a", 1'b0, usbDataPortAPulldown);
    chk("pd b", 1'b0, usbDataPortBPulldown);
    chk("conf", 3'h7, phyConfigPins);
    chk("pwr", 9'h1FF, {powerSignalValid, powerSignalData});
    chk("otg", 32'hFFFFFFFF, onTheGoFlagMask);
    for (int i = 0; i < 4; i++)
      wr(8'h34 + 8'(4 * i), 32'h0);
    @(posedge clock);
    chk("pd on", 1'b1, usbDataPortBPulldown);
    wr(8'h50, 32'hFFFFFFFF);
    rd("unmapped", 8'h50, 32'h0);
    suspendRequest <= 1'b1;
    @(posedge clock);
    suspendRequest <= 1'b0;
    @(posedge clock);
    chk("no sleep", 1'b1, phySuspendN);
  endtask : t_regs

  task automatic rxone(input logic [3:0] ep, input logic [4:0] e);
    @(posedge clock);
    rxEndpointValid <= 1'b1;
    rxEndpoint <= ep;
    @(posedge clock);
    rxEndpointValid <= 1'b0;
    @(posedge clock);
    chk("rx valid", 1'b1, rxPortValid);
    chk("rx ep", e, rxPortEndpoint);
  endtask : rxone

  task automatic t_filter();
    wr(8'h40, 32'h200);
    wr(8'h48, 32'h0);
    waitf(2'h1);
    rd("line", 8'h4C, 32'h1);
    rd("stat", 8'h44, 32'h4);
    lineReq <= 2'h2;
    repeat (2) @(posedge clock);
    lineReq <= 2'h1;
    repeat (20) @(posedge clock);
    chk("glitch", 2'h1, lineStateFiltered);
    lineReq <= 2'h2;
    repeat (4) @(posedge clock);
    chk("early", 2'h1, lineStateFiltered);
    waitf(2'h2);
    chk("irq off", 1'b0, irq);
    wr(8'h48, 32'h4);
    repeat (2) @(posedge clock);
    chk("irq on", 1'b1, irq);
    rd("stat", 8'h44, 32'h4);
    repeat (2) @(posedge clock);
    chk("irq clr", 1'b0, irq);
    lineReq <= 2'h1;
    waitf(2'h1);
    rd("stat", 8'h44, 32'h4);
  endtask : t_filter

  task automatic t_resume(input logic [1:0] code, input logic [31:0] cb,
    input logic [31:0] sb);
    wr(8'h40, 32'h80);
    wr(8'h48, 32'h3);
    suspendRequest <= 1'b1;
    @(posedge clock);
    suspendRequest <= 1'b0;
    @(posedge clock);
    chk("asleep", 1'b0, phySuspendN);
    lineReq <= code;
    waitf(code);
    repeat (2) @(posedge clock);
    chk("awake", 1'b1, phySuspendN);
    chk("irq", 1'b1, irq);
    rd("cause", 8'h40, 32'h80 | cb);
    rd("stat", 8'h44, 32'h4 | sb);
    wr(8'h40, 32'h80);
    rd("cleared", 8'h40, 32'h80);
    lineReq <= 2'h1;
    waitf(2'h1);
    rd("stat", 8'h44, 32'h4);
  endtask : t_resume

  // clearing the enable while asleep wakes with no resume cause
  task automatic t_wake();
    wr(8'h40, 32'h80);
    suspendRequest <= 1'b1;
    @(posedge clock);
    suspendRequest <= 1'b0;
    @(posedge clock);
    chk("asleep", 1'b0, phySuspendN);
    wr(8'h40, 32'h0);
    repeat (2) @(posedge clock);
    chk("sw wake", 1'b1, phySuspendN);
    rd("no cause", 8'h40, 32'h0);
  endtask : t_wake

  initial
  begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    wr(8'h34, 32'h8008);
    rxone(4'h3, 5'h13);
    rxone(4'hF, 5'h1F);
    rxone(4'h4, 5'h04);
    t_filter();
    t_resume(2'h2, 32'h1000, 32'h1);
    t_resume(2'h0, 32'h2000, 32'h2);
    t_wake();
    complete_run();
  end
endmodule : tb
